// *** rtl/bbc_map.svh ***
// Purpose: Register offsets, field positions and reset values of the byte compare unit
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: Definitions only
`ifndef BBC_MAP_SVH
`define BBC_MAP_SVH
`define BBC_OFF_CTRL 6'h00
`define BBC_OFF_STATUS 6'h04
`define BBC_OFF_FIRST 6'h08
`define BBC_OFF_SECOND 6'h0C
`define BBC_OFF_REF 6'h10
`define BBC_OFF_COUNT 6'h14
`define BBC_CTRL_START 0
`define BBC_CTRL_MODE_LO 1
`define BBC_CTRL_MODE_HI 2
`define BBC_CTRL_DIR 3
`define BBC_ST_BUSY 0
`define BBC_ST_SUSP 1
`define BBC_ST_DONE 2
`define BBC_ST_FLAG_LO 4
`define BBC_ST_FLAG_HI 8
`define BBC_RST_PTR 24'h00_0000
`define BBC_RST_BYTE 8'h00
`define BBC_RESP_OKAY 2'b00
`define BBC_RESP_SLVERR 2'b10
`endif

// *** rtl/bbc_pkg.sv ***
// Purpose: Types shared by the byte compare unit
// Assumes: Nothing beyond the map header
// Notes: Flags are ordered s, z, ac, pv, cy from high to low
package bbc_pkg;
  typedef enum logic [1:0] {
    BBC_SCAN_UNTIL_REF_GREATER = 2'h0,
    BBC_BLOCK_COMPARE_WHILE_EQUAL = 2'h1,
    BBC_BLOCK_COMPARE_UNTIL_MATCH = 2'h2,
    BBC_BLOCK_COMPARE_WHILE_BELOW = 2'h3
  } bbc_mode_t;
  typedef enum logic [4:0] {
    BBC_IDLE = 5'b0_0001,
    BBC_RD1 = 5'b0_0010,
    BBC_RD2 = 5'b0_0100,
    BBC_EXEC = 5'b0_1000,
    BBC_SUSP = 5'b1_0000
  } bbc_state_t;
  typedef struct packed {
    logic negative_bit;
    logic null_result_bit;
    logic half_borrow_bit;
    logic overflow_bit;
    logic borrow_out_bit;
  } bbc_flags_t;
endpackage

// *** rtl/bbc_sub8.sv ***
// Purpose: 8-bit subtractor with the five arithmetic flags
// Assumes: Purely combinational, same clock as the caller
// Notes: Borrow chain is explicit so the per-bit borrows feed the flags
`timescale 1ns/1ps
`default_nettype none
module bbc_sub8
  import bbc_pkg::*;
(
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  output logic [7:0] diff,
  output bbc_flags_t flags
);
  logic [8:0] brw;

  // Ripple borrow chain, one stage per bit
  assign brw[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      assign diff[i] = minuend[i] ^ subtrahend[i] ^ brw[i];
      assign brw[i+1] = (~minuend[i] & subtrahend[i]) | (~(minuend[i] ^ subtrahend[i]) & brw[i]);
    end
  endgenerate

  // Flags from the result and the borrows
  assign flags.negative_bit = diff[7];
  assign flags.null_result_bit = (diff == 8'h00);
  assign flags.half_borrow_bit = brw[4];
  assign flags.overflow_bit = brw[7] ^ brw[8];
  assign flags.borrow_out_bit = brw[8];
endmodule
`default_nettype wire

// *** rtl/bbc_core.sv ***
// Purpose: Repeated byte compare engine with an AXI4-Lite register file
// Assumes: Memory read port and suspend requests come from logic on aclk
// Notes: Only reads memory; there is no write path to either block
// How it works
// - Scan form compares reference with byte at first pointer, steps, counts, stops.
// - Scan form never changes the reference byte or memory.
// - While-equal form stops on nonzero result or count zero.
// - Until-match form stops on zero result or count zero.
// - While-below form stops when no borrow occurs or count zero.
// - Two-block forms step both pointers by one, up or down, count down.
// - Two-block forms only read both blocks, never write.
// - Interrupt or macro service request suspends the loop between iterations.
// - Interrupt return resumes with pointers and count as the handler left them.
// - Macro service suspension resumes automatically when the transfer ends.
// - Flags show only the final subtraction.
// - Negative flag copies bit 7 of the result.
// - Null flag set when the result is zero.
// - Half borrow flag set on borrow from bit 4 into bit 3.
// - Overflow flag set when exactly one of bit 6, bit 7 borrows.
// - Borrow flag set on borrow out of bit 7.
// - Scan form subtracts reference from memory byte, ends on borrow.
`timescale 1ns/1ps
`default_nettype none
`include "bbc_map.svh"
module bbc_core
  import bbc_pkg::*;
#(
  parameter int PTR_W = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mem_req,
  output logic [PTR_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  input wire logic intr_req,
  input wire logic intr_return,
  input wire logic ms_req,
  input wire logic ms_done,
  output logic suspend_ack,
  output logic done_pulse
);
  localparam logic [PTR_W-1:0] PTR_ONE = {{(PTR_W-1){1'b0}}, 1'b1};

  bbc_state_t state_reg, state_next;
  bbc_mode_t mode_reg;
  bbc_flags_t flags_reg, sub_flags;
  logic dir_reg;
  logic [PTR_W-1:0] first_ptr_reg, second_ptr_reg, first_step, second_step;
  logic [7:0] ref_reg, count_reg, count_dec, byte_a_reg, byte_b_reg, sub_b, sub_diff;
  logic susp_macro_reg, done_reg, stop_cond, last_iter, want_susp;
  logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [5:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic wr_fire, edit_ok, start_wr, wr_mapped;
  logic [31:0] wr_val_ptr1, wr_val_ptr2, wr_val_ref, wr_val_cnt;

  // Merge a write into an old word by byte lanes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int k = 0; k < 4; k++) begin
      if (strb[k]) begin
        res[k*8 +: 8] = new_w[k*8 +: 8];
      end
    end
    return res;
  endfunction

  // Two-block forms subtract the second byte; scan subtracts the reference
  assign sub_b = (mode_reg == BBC_SCAN_UNTIL_REF_GREATER) ? ref_reg : byte_b_reg;
  bbc_sub8 u_sub (
    .minuend(byte_a_reg),
    .subtrahend(sub_b),
    .diff(sub_diff),
    .flags(sub_flags)
  );

  // Step values wrap at the pointer width
  assign first_step = dir_reg ? (first_ptr_reg - PTR_ONE) : (first_ptr_reg + PTR_ONE);
  assign second_step = dir_reg ? (second_ptr_reg - PTR_ONE) : (second_ptr_reg + PTR_ONE);
  assign count_dec = count_reg - 8'h01;
  assign last_iter = (count_dec == 8'h00);
  assign want_susp = intr_req | ms_req;

  // Termination condition of each form
  always_comb begin
    unique case (mode_reg)
      BBC_SCAN_UNTIL_REF_GREATER: stop_cond = sub_flags.borrow_out_bit;
      BBC_BLOCK_COMPARE_WHILE_EQUAL: stop_cond = ~sub_flags.null_result_bit;
      BBC_BLOCK_COMPARE_UNTIL_MATCH: stop_cond = sub_flags.null_result_bit;
      BBC_BLOCK_COMPARE_WHILE_BELOW: stop_cond = ~sub_flags.borrow_out_bit;
    endcase
  end

  // Bus write decode; pointers and count only change when the loop is not running
  assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign edit_ok = (state_reg == BBC_IDLE) || (state_reg == BBC_SUSP);
  assign start_wr = wr_fire && (aw_addr_reg == `BBC_OFF_CTRL) && w_strb_reg[0] &&
                    w_data_reg[`BBC_CTRL_START] && (state_reg == BBC_IDLE);
  assign wr_val_ptr1 = merge_strb({{(32-PTR_W){1'b0}}, first_ptr_reg}, w_data_reg, w_strb_reg);
  assign wr_val_ptr2 = merge_strb({{(32-PTR_W){1'b0}}, second_ptr_reg}, w_data_reg, w_strb_reg);
  assign wr_val_ref = merge_strb({24'h00_0000, ref_reg}, w_data_reg, w_strb_reg);
  assign wr_val_cnt = merge_strb({24'h00_0000, count_reg}, w_data_reg, w_strb_reg);
  always_comb begin
    unique case (aw_addr_reg)
      `BBC_OFF_CTRL, `BBC_OFF_STATUS, `BBC_OFF_FIRST, `BBC_OFF_SECOND, `BBC_OFF_REF, `BBC_OFF_COUNT:
        wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // Sequencer: suspension is only checked after a whole iteration
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BBC_IDLE: if (start_wr) begin
        state_next = BBC_RD1;
      end
      BBC_RD1: if (mem_ack) begin
        state_next = (mode_reg == BBC_SCAN_UNTIL_REF_GREATER) ? BBC_EXEC : BBC_RD2;
      end
      BBC_RD2: if (mem_ack) begin
        state_next = BBC_EXEC;
      end
      BBC_EXEC: begin
        if (stop_cond || last_iter) begin
          state_next = BBC_IDLE;
        end else if (want_susp) begin
          state_next = BBC_SUSP;
        end else begin
          state_next = BBC_RD1;
        end
      end
      BBC_SUSP: begin
        if (susp_macro_reg ? ms_done : intr_return) begin
          state_next = BBC_RD1;
        end
      end
      default: state_next = BBC_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= BBC_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Suspension bookkeeping; macro service takes priority when both arrive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      susp_macro_reg <= 1'b0;
      suspend_ack <= 1'b0;
      done_pulse <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce) begin
      suspend_ack <= (state_reg == BBC_EXEC) && (state_next == BBC_SUSP);
      done_pulse <= (state_reg == BBC_EXEC) && (state_next == BBC_IDLE);
      if ((state_reg == BBC_EXEC) && (state_next == BBC_SUSP)) begin
        susp_macro_reg <= ms_req;
      end
      if (start_wr) begin
        done_reg <= 1'b0;
      end else if ((state_reg == BBC_EXEC) && (state_next == BBC_IDLE)) begin
        done_reg <= 1'b1;
      end
    end
  end

  // Memory read port: request held until acknowledged, no write path exists
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_req <= 1'b0;
      mem_addr <= `BBC_RST_PTR;
    end else if (ce) begin
      if (state_next == BBC_RD1 && state_reg != BBC_RD1) begin
        mem_req <= 1'b1;
        mem_addr <= (state_reg == BBC_EXEC) ? first_step : first_ptr_reg;
      end else if (state_next == BBC_RD2 && state_reg == BBC_RD1) begin
        mem_req <= 1'b1;
        mem_addr <= second_ptr_reg;
      end else if (mem_ack) begin
        mem_req <= 1'b0;
      end
    end
  end

  // Operand capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_a_reg <= `BBC_RST_BYTE;
      byte_b_reg <= `BBC_RST_BYTE;
    end else if (ce) begin
      if (state_reg == BBC_RD1 && mem_ack) begin
        byte_a_reg <= mem_rdata;
      end
      if (state_reg == BBC_RD2 && mem_ack) begin
        byte_b_reg <= mem_rdata;
      end
    end
  end

  // Flags overwritten by every subtraction, so the last one stands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= '0;
    end else if (ce && state_reg == BBC_EXEC) begin
      flags_reg <= sub_flags;
    end
  end

  // Pointers and count: stepped by the loop, editable by software when not running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_ptr_reg <= `BBC_RST_PTR;
      second_ptr_reg <= `BBC_RST_PTR;
      count_reg <= `BBC_RST_BYTE;
    end else if (ce) begin
      if (state_reg == BBC_EXEC) begin
        first_ptr_reg <= first_step;
        count_reg <= count_dec;
        if (mode_reg != BBC_SCAN_UNTIL_REF_GREATER) begin
          second_ptr_reg <= second_step;
        end
      end else if (wr_fire && edit_ok) begin
        if (aw_addr_reg == `BBC_OFF_FIRST) begin
          first_ptr_reg <= wr_val_ptr1[PTR_W-1:0];
        end
        if (aw_addr_reg == `BBC_OFF_SECOND) begin
          second_ptr_reg <= wr_val_ptr2[PTR_W-1:0];
        end
        if (aw_addr_reg == `BBC_OFF_COUNT) begin
          count_reg <= wr_val_cnt[7:0];
        end
      end
    end
  end

  // Mode, direction and reference only change while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= BBC_SCAN_UNTIL_REF_GREATER;
      dir_reg <= 1'b0;
      ref_reg <= `BBC_RST_BYTE;
    end else if (ce && wr_fire && state_reg == BBC_IDLE) begin
      if (aw_addr_reg == `BBC_OFF_CTRL && w_strb_reg[0]) begin
        mode_reg <= bbc_mode_t'(w_data_reg[`BBC_CTRL_MODE_HI:`BBC_CTRL_MODE_LO]);
        dir_reg <= w_data_reg[`BBC_CTRL_DIR];
      end
      if (aw_addr_reg == `BBC_OFF_REF) begin
        ref_reg <= wr_val_ref[7:0];
      end
    end
  end

  // AXI write channels: address and data taken in either order
  assign s_axi_awready = ce & ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready = ce & ~w_hold_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      aw_addr_reg <= 6'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bresp_reg <= `BBC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? `BBC_RESP_OKAY : `BBC_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // AXI read channel: one cycle from address to data
  assign s_axi_arready = ce & ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `BBC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= `BBC_RESP_OKAY;
        rdata_reg <= 32'h0000_0000;
        unique case ({s_axi_araddr[5:2], 2'b00})
          `BBC_OFF_CTRL: rdata_reg <= {28'h000_0000, dir_reg, mode_reg, 1'b0};
          `BBC_OFF_STATUS: rdata_reg <= {23'h00_0000, flags_reg, 1'b0, done_reg,
                                         state_reg == BBC_SUSP, state_reg != BBC_IDLE};
          `BBC_OFF_FIRST: rdata_reg <= {{(32-PTR_W){1'b0}}, first_ptr_reg};
          `BBC_OFF_SECOND: rdata_reg <= {{(32-PTR_W){1'b0}}, second_ptr_reg};
          `BBC_OFF_REF: rdata_reg <= {24'h00_0000, ref_reg};
          `BBC_OFF_COUNT: rdata_reg <= {24'h00_0000, count_reg};
          default: rresp_reg <= `BBC_RESP_SLVERR;
        endcase
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Checks on the loop
  a_scan_stop_borrow: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && state_reg == BBC_EXEC && mode_reg == BBC_SCAN_UNTIL_REF_GREATER && byte_a_reg < ref_reg)
    |=> state_reg == BBC_IDLE && flags_reg.borrow_out_bit)
    else $error("scan did not stop on borrow");
  a_equal_stop_diff: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && state_reg == BBC_EXEC && mode_reg == BBC_BLOCK_COMPARE_WHILE_EQUAL && byte_a_reg != byte_b_reg)
    |=> state_reg == BBC_IDLE)
    else $error("while-equal did not stop on mismatch");
  a_match_stop_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && state_reg == BBC_EXEC && mode_reg == BBC_BLOCK_COMPARE_UNTIL_MATCH && byte_a_reg == byte_b_reg)
    |=> state_reg == BBC_IDLE && flags_reg.null_result_bit)
    else $error("until-match did not stop on match");
  a_below_continue: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && state_reg == BBC_EXEC && mode_reg == BBC_BLOCK_COMPARE_WHILE_BELOW && byte_a_reg < byte_b_reg
     && count_reg != 8'h01 && !want_susp)
    |=> state_reg == BBC_RD1)
    else $error("while-below stopped while below");
  a_ptr_step_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && state_reg == BBC_EXEC && mode_reg != BBC_SCAN_UNTIL_REF_GREATER)
    |=> (first_ptr_reg - $past(first_ptr_reg)) == (second_ptr_reg - $past(second_ptr_reg))
        && (first_ptr_reg - $past(first_ptr_reg)) == ($past(dir_reg) ? {PTR_W{1'b1}} : PTR_ONE))
    else $error("pointers did not step together by one");
  a_count_last: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && state_reg == BBC_EXEC && count_reg == 8'h01) |=> state_reg == BBC_IDLE && count_reg == 8'h00)
    else $error("loop did not end when count reached zero");
  a_ref_stable_run: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg != BBC_IDLE) |=> $stable(ref_reg) && $stable(mode_reg))
    else $error("reference changed while running");
  a_flag_zero_sub: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && state_reg == BBC_EXEC) |=> flags_reg.null_result_bit == ($past(byte_a_reg) == $past(sub_b))
        && flags_reg.negative_bit == $past(sub_diff[7]))
    else $error("flags do not match the last subtraction");
  a_susp_on_req: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && state_reg == BBC_EXEC && want_susp && !stop_cond && !last_iter)
    |=> state_reg == BBC_SUSP && suspend_ack)
    else $error("request did not suspend the loop");
  a_ms_resume_auto: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && state_reg == BBC_SUSP && susp_macro_reg && ms_done) |=> state_reg == BBC_RD1 && mem_req)
    else $error("macro service end did not resume");
  a_mem_req_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_req && !mem_ack) |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped before acknowledge");
endmodule
`default_nettype wire

// *** bench/bbc_mem_model.sv ***
// Purpose: Byte-wide read memory on the far side of the compare unit
// Assumes: One clock, a request is held until it is acknowledged
// Notes: Contents come from an image owned by the bench; there is no write path
`timescale 1ns/1ps
`default_nettype none
module bbc_mem_model (
  input wire logic aclk,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0] img [256],
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  int wait_cnt = 0;
  logic [7:0] last = 8'h00;

  initial begin
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
  end

  // Answer at once or after a random wait; idle data is inverted so stale bytes never look valid
  always @(posedge aclk) begin
    if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~last;
      wait_cnt <= slow ? $urandom_range(4, 1) : 0;
    end else if (mem_req && wait_cnt == 0) begin
      mem_ack <= 1'b1;
      mem_rdata <= img[mem_addr[7:0]];
      last <= img[mem_addr[7:0]];
    end else if (mem_req) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule
`default_nettype wire

// *** bench/bbc_core_tb_top.sv ***
// Purpose: Self-checking bench for the repeated byte compare engine
// Assumes: Memory image aliases on the low address byte only
// Notes: Expectations come from a bench-side loop model, never from the design
`timescale 1ns/1ps
`default_nettype none
`include "bbc_map.svh"
module bbc_core_tb_top
  import bbc_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, slow = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic intr_req = 1'b0, intr_return = 1'b0, ms_req = 1'b0, ms_done = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, mem_req, mem_ack, suspend_ack, done_pulse;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] mem_addr, e_f, e_s;
  logic [7:0] mem_rdata, e_c, e_r;
  logic [7:0] img [256];
  bbc_flags_t e_fl;
  int errors = 0, num_checks = 0;

  always #10 aclk = ~aclk;

  bbc_core bbc_core_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .intr_req(intr_req), .intr_return(intr_return), .ms_req(ms_req), .ms_done(ms_done),
    .suspend_ack(suspend_ack), .done_pulse(done_pulse));

  bbc_mem_model bbc_mem_model_i (.aclk(aclk), .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
    .img(img), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each released at the edge that takes it
  task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while ((awvalid && !ta) || (wvalid && !tw));
    do @(negedge aclk); while (!bvalid);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
  endtask

  // Borrow chain taps: out of bit 3, out of bit 6, out of bit 7
  function automatic bbc_flags_t flg(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] d8;
    logic [4:0] d3;
    logic [7:0] d6;
    d8 = {1'b0, a} - {1'b0, b};
    d3 = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    d6 = {1'b0, a[6:0]} - {1'b0, b[6:0]};
    flg = '{d8[7], d8[7:0] == 8'h00, d3[4], d6[7] ^ d8[8], d8[8]};
  endfunction

  // Loop model; count is tested after the decrement, so zero means 256 passes
  task automatic predict(input bbc_mode_t m, input logic dn);
    logic stop;
    do begin
      e_fl = flg(img[e_f[7:0]], m == BBC_SCAN_UNTIL_REF_GREATER ? e_r : img[e_s[7:0]]);
      e_f = dn ? e_f - 24'h00_0001 : e_f + 24'h00_0001;
      if (m != BBC_SCAN_UNTIL_REF_GREATER) e_s = dn ? e_s - 24'h00_0001 : e_s + 24'h00_0001;
      e_c = e_c - 8'h01;
      case (m)
        BBC_SCAN_UNTIL_REF_GREATER: stop = e_fl.borrow_out_bit;
        BBC_BLOCK_COMPARE_WHILE_EQUAL: stop = !e_fl.null_result_bit;
        BBC_BLOCK_COMPARE_UNTIL_MATCH: stop = e_fl.null_result_bit;
        default: stop = !e_fl.borrow_out_bit;
      endcase
    end while (!stop && e_c != 8'h00);
  endtask

  task automatic start(input bbc_mode_t m, input logic dn, input logic [7:0] rf);
    logic [1:0] r;
    e_r = rf;
    wr(`BBC_OFF_FIRST, {8'h00, e_f}, r);
    wr(`BBC_OFF_SECOND, {8'h00, e_s}, r);
    wr(`BBC_OFF_REF, {24'h00_0000, rf}, r);
    wr(`BBC_OFF_COUNT, {24'h00_0000, e_c}, r);
    wr(`BBC_OFF_CTRL, {28'h000_0000, dn, m, 1'b1}, r);
    predict(m, dn);
  endtask

  task automatic wait_ev(input int which);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!(which ? suspend_ack : done_pulse) && n < 5000);
    chk({31'h0000_0000, which ? suspend_ack : done_pulse}, 32'h0000_0001);
  endtask

  task automatic verify();
    rchk(`BBC_OFF_FIRST, {8'h00, e_f});
    rchk(`BBC_OFF_SECOND, {8'h00, e_s});
    rchk(`BBC_OFF_COUNT, {24'h00_0000, e_c});
    rchk(`BBC_OFF_REF, {24'h00_0000, e_r});
    rchk(`BBC_OFF_STATUS, {23'h00_0000, e_fl, 1'b0, 3'b100});
  endtask

  // Hang guard, sized well above the longest expected run
  initial begin
    repeat (60000) @(posedge aclk);
    errors++;
    close_out();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    d = $urandom(32'hca930eb6);
    // Half random bytes, half coarse values so matches and borrows both occur
    foreach (img[k]) img[k] = $urandom_range(1, 0) ? 8'($urandom()) : 8'($urandom_range(3, 0) * 64);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`BBC_OFF_STATUS, 32'h0000_0000);
    rchk(`BBC_OFF_FIRST, 32'h0000_0000);
    rd(6'h18, d, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, `BBC_RESP_SLVERR});
    wr(6'h3C, 32'hFFFF_FFFF, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, `BBC_RESP_SLVERR});
    $display("test reset_and_map done");
    // Every mode in both directions, prompt and slow memory
    for (int i = 0; i < 32; i++) begin
      slow <= i[3];
      e_f = 24'($urandom());
      e_s = 24'($urandom());
      e_c = 8'($urandom_range(9, 1));
      start(bbc_mode_t'(i[1:0]), i[2], 8'($urandom()));
      wait_ev(0);
      verify();
    end
    $display("test random_modes done");
    // Zero count runs 256 passes and the first pointer wraps at both ends
    for (int k = 0; k < 2; k++) begin
      e_f = k ? 24'h00_0003 : 24'hFF_FFF0;
      e_s = 24'h12_3456;
      e_c = 8'h00;
      start(BBC_SCAN_UNTIL_REF_GREATER, k[0], 8'h00);
      wait_ev(0);
      verify();
    end
    $display("test wrap_and_full_count done");
    // Suspend by interrupt then by macro service; handler leaves state alone
    for (int k = 0; k < 2; k++) begin
      slow <= 1'b1;
      e_f = 24'h00_1000;
      e_s = 24'h00_2080;
      e_c = 8'h40;
      // First block stays below the second for bytes 0 to 49, so the loop lives long enough to be suspended
      for (int j = 0; j < 64; j++) begin
        img[j] = 8'(j);
        img[j + 128] = 8'(j + (j < 50 ? 1 : 0));
      end
      start(BBC_BLOCK_COMPARE_WHILE_BELOW, 1'b0, 8'h00);
      @(posedge aclk);
      intr_req <= k == 0;
      ms_req <= k == 1;
      wait_ev(1);
      @(posedge aclk);
      intr_req <= 1'b0;
      ms_req <= 1'b0;
      rd(`BBC_OFF_STATUS, d, r);
      chk(d & 32'h0000_0002, 32'h0000_0002);
      // A return pulse while the clock enable is low is lost, so the loop must stay suspended
      @(posedge aclk);
      ce <= 1'b0;
      intr_return <= k == 0;
      ms_done <= k == 1;
      @(posedge aclk);
      ce <= 1'b1;
      intr_return <= 1'b0;
      ms_done <= 1'b0;
      rd(`BBC_OFF_STATUS, d, r);
      chk(d & 32'h0000_0002, 32'h0000_0002);
      @(posedge aclk);
      intr_return <= k == 0;
      ms_done <= k == 1;
      @(posedge aclk);
      intr_return <= 1'b0;
      ms_done <= 1'b0;
      wait_ev(0);
      verify();
    end
    $display("test suspend_resume done");
    close_out();
  end
endmodule
`default_nettype wire
